// ==== ast_top.sv ====
// audio serial transceiver: wishbone registers, fifos, framer, shifter
// assumes pins are synchronous to clk; one clock domain
//
// Local design decisions: the Wishbone slave port and the register addresses.
`default_nettype none
`include "ast_params.svh"
module ast_top (
   input  wire logic        clk,                      // bus clock 10 MHz
   input  wire logic        reset_n,                  // sync reset
   input  wire logic        wb_cyc,                   // bus cycle
   input  wire logic        wb_stb,                   // strobe
   input  wire logic        wb_we,                    // write enable
   input  wire logic [7:0]  wb_adr,                   // byte address
   input  wire logic [3:0]  wb_sel,                   // byte lanes
   input  wire logic [31:0] wb_dat_w,                 // write data
   output logic      [31:0] wb_dat_r,                 // read data
   output logic             wb_ack,                   // answer
   input  wire logic        audio_kernel_clock,       // internal source
   input  wire logic        external_audio_clock_pin, // external source
   input  wire logic        sck_in,                   // bit clock pin in
   output logic             sck_out,                  // bit clock drive
   output logic             sck_oe,                   // bit clock enable
   input  wire logic        ws_in,                    // word select in
   output logic             ws_out,                   // word select drive
   output logic             ws_oe,                    // word select enable
   input  wire logic        sd_in,                    // serial data in
   output logic             sd_out,                   // serial data out
   output logic             mclk_out,                 // master clock out
   output logic             irq                       // interrupt, high
);
   import ast_pkg::*;

   logic [31:0] ctrl, next_ctrl;
   logic [7:0]  presc, next_presc;
   logic [`AST_NSTAT-1:0] stat, next_stat, mask, next_mask, ev;
   logic [31:0] next_rdat;
   logic        next_ack, rx_take, next_rx_take;
   logic        acc, wr, rd;
   logic [7:0]  adr;
   logic        tx_push, tx_pop, tx_full, tx_empty;
   logic        rx_push, rx_pop, rx_full, rx_empty;
   logic [31:0] tx_head, rx_head;
   logic [2:0]  tx_level, rx_level;
   logic        src_q, src_prev, next_src_q;
   logic        d_mclk, d_bclk, d_rise, d_fall;
   ast_state_t  state, next_state;
   logic        run, master, pcm;
   ast_fmt_t    fmt;
   logic [5:0]  slot, dl;
   logic [4:0]  start;
   logic [4:0]  pos, next_pos, txrem, next_txrem, rxrem, next_rxrem;
   logic        ch, next_ch, ws_q, next_ws_q, sck_q, next_sck_q;
   logic        ws_drv, next_ws_drv, sd_drv, next_sd_drv;
   logic [31:0] txsh, next_txsh, rxsh, next_rxsh;
   logic        fall, rise, bound, last, load, rx_done;
   logic        tx_load_udf;

   // byte-lane merge for the control register
   function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            old[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return old;
   endfunction

   // access completes at the edge where ack is high
   assign adr = {wb_adr[7:2], 2'h0};
   assign acc = wb_cyc & wb_stb & wb_ack;
   assign wr  = acc & wb_we;
   assign rd  = acc & ~wb_we;

   // decode fields
   assign run    = (state == AST_RUN);
   assign master = ctrl[`AST_CTRL_MASTER];
   assign fmt    = ast_fmt_t'(ctrl[`AST_CTRL_FMT]);
   assign pcm    = (fmt == AST_FMT_PCM);

   // slot and sample lengths; a 24/32-bit sample in a 16 slot is cut
   always_comb begin
      slot = ctrl[`AST_CTRL_CH32] ? 6'd32 : 6'd16;
      unique case (ast_dlen_t'(ctrl[`AST_CTRL_DLEN]))
         AST_DL16: dl = 6'd16;
         AST_DL24: dl = 6'd24;
         AST_DL32: dl = 6'd32;
         AST_DLX:  dl = 6'd32;
      endcase
      if (dl > slot) begin
         dl = slot;
      end
      unique case (fmt)
         AST_FMT_LJ:  start = 5'd0;
         AST_FMT_RJ:  start = 5'(slot - dl);
         AST_FMT_STD: start = 5'd1;
         AST_FMT_PCM: start = 5'd1;
      endcase
   end

   // register writes, w1c status; a new event beats a clear
   always_comb begin
      next_ctrl  = ctrl;
      next_presc = presc;
      next_mask  = mask;
      next_stat  = stat | ev;
      if (wr && adr == `AST_ADR_CTRL) begin
         next_ctrl = merge(ctrl, wb_dat_w, wb_sel);
      end
      if (wr && adr == `AST_ADR_PRESC && wb_sel[0]) begin
         next_presc = wb_dat_w[7:0];
      end
      if (wr && adr == `AST_ADR_MASK && wb_sel[0]) begin
         next_mask = wb_dat_w[`AST_NSTAT-1:0];
      end
      if (wr && adr == `AST_ADR_STAT && wb_sel[0]) begin
         next_stat = (stat & ~wb_dat_w[`AST_NSTAT-1:0]) | ev;
      end
   end

   // read data latched with the request; unmapped reads give zero
   always_comb begin
      next_ack     = wb_cyc & wb_stb & ~wb_ack;
      next_rdat    = wb_dat_r;
      next_rx_take = rx_take;
      if (next_ack) begin
         next_rx_take = 1'b0;
         unique case (adr)
            `AST_ADR_CTRL:  next_rdat = ctrl;
            `AST_ADR_PRESC: next_rdat = {24'h0, presc};
            `AST_ADR_STAT:  next_rdat = {27'h0, stat};
            `AST_ADR_MASK:  next_rdat = {27'h0, mask};
            `AST_ADR_LEVEL: next_rdat = {23'h0, run, 1'b0, rx_level,
                                         1'b0, tx_level};
            `AST_ADR_RXDATA: begin
               next_rdat    = rx_empty ? 32'h0 : rx_head;
               next_rx_take = ~wb_we & ~rx_empty;
            end
            default: next_rdat = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ctrl     <= `AST_RST_CTRL;
         presc    <= `AST_RST_PRESC;
         mask     <= `AST_RST_MASK;
         stat     <= '0;
         wb_ack   <= 1'b0;
         wb_dat_r <= 32'h0;
         rx_take  <= 1'b0;
      end else begin
         ctrl     <= next_ctrl;
         presc    <= next_presc;
         mask     <= next_mask;
         stat     <= next_stat;
         wb_ack   <= next_ack;
         wb_dat_r <= next_rdat;
         rx_take  <= next_rx_take;
      end
   end

   // events; alarms are levels so they re-arm while the condition holds
   always_comb begin
      ev = '0;
      ev[`AST_ST_TXA] = run & ctrl[`AST_CTRL_TXEN] &
         (3'h4 - tx_level >= ctrl[`AST_CTRL_TXTHR]);
      ev[`AST_ST_RXA] = run & ctrl[`AST_CTRL_RXEN] &
         (rx_level >= ctrl[`AST_CTRL_RXTHR]);
      ev[`AST_ST_RXOVF] = rx_done & rx_full;
      ev[`AST_ST_TXUDF] = tx_load_udf;
      ev[`AST_ST_TXOVF] = wr & (adr == `AST_ADR_TXDATA) & tx_full;
   end
   assign irq = |(stat & mask);

   // fifo traffic; a write to a full fifo is dropped
   assign tx_push = wr & (adr == `AST_ADR_TXDATA) & ~tx_full;
   assign tx_pop  = load & ctrl[`AST_CTRL_TXEN] & ~tx_empty;
   assign rx_push = rx_done & ~rx_full;
   assign rx_pop  = rd & (adr == `AST_ADR_RXDATA) & rx_take;

   ast_fifo u_txf (
      .clk       (clk),
      .reset_n   (reset_n),
      .push      (tx_push),
      .push_data (wb_dat_w),
      .pop       (tx_pop),
      .head      (tx_head),
      .full      (tx_full),
      .empty     (tx_empty),
      .level     (tx_level)
   );

   ast_fifo u_rxf (
      .clk       (clk),
      .reset_n   (reset_n),
      .push      (rx_push),
      .push_data (next_rxsh),
      .pop       (rx_pop),
      .head      (rx_head),
      .full      (rx_full),
      .empty     (rx_empty),
      .level     (rx_level)
   );

   // clock source select and edge detect; pins already synchronous
   always_comb begin
      next_src_q = ctrl[`AST_CTRL_EXTCLK] ? external_audio_clock_pin
                                          : audio_kernel_clock;
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         src_q    <= 1'b0;
         src_prev <= 1'b0;
      end else begin
         src_q    <= next_src_q;
         src_prev <= src_q;
      end
   end

   // Fs = source / (2 * presc * 256); presc picks 192k..8k
   ast_clkdiv u_div (
      .clk       (clk),
      .reset_n   (reset_n),
      .run       (run & master),
      .src_edge  (src_q & ~src_prev),
      .presc     (presc),
      .ch32      (ctrl[`AST_CTRL_CH32]),
      .mclk      (d_mclk),
      .bclk      (d_bclk),
      .bclk_rise (d_rise),
      .bclk_fall (d_fall)
   );

   // pin drive; slave leaves clock and word select undriven
   assign sck_out  = d_bclk;
   assign sck_oe   = run & master;
   assign ws_out   = ws_drv;
   assign ws_oe    = run & master;
   assign sd_out   = sd_drv;
   assign mclk_out = d_mclk & ctrl[`AST_CTRL_MCKEN];

   // edges: own divider as master, sampled pin as slave
   assign fall  = master ? d_fall : (sck_q & ~sck_in);
   assign rise  = master ? d_rise : (~sck_q & sck_in);
   assign last  = ({1'b0, pos} == slot - 6'd1);
   assign bound = ~master & (pcm ? (ws_in & ~ws_q) : (ws_in != ws_q));

   // run state: bit counters cleared and slot position parked on its last bit while off
   always_comb begin
      unique case (state)
         AST_OFF: next_state = ctrl[`AST_CTRL_EN] ? AST_RUN : AST_OFF;
         AST_RUN: next_state = ctrl[`AST_CTRL_EN] ? AST_RUN : AST_OFF;
         default: next_state = AST_OFF;
      endcase
   end

   // framer and shifters: drive on falling, sample on rising edge
   always_comb begin
      next_pos    = pos;
      next_ch     = ch;
      next_ws_q   = ws_q;
      next_ws_drv = ws_drv;
      next_sd_drv = sd_drv;
      next_txsh   = txsh;
      next_txrem  = txrem;
      next_rxsh   = rxsh;
      next_rxrem  = rxrem;
      next_sck_q  = sck_in;
      load        = 1'b0;
      tx_load_udf = 1'b0;
      rx_done     = 1'b0;
      if (run && fall) begin
         // word select flips per slot; pcm gives a one-bit frame pulse
         next_pos  = bound ? 5'd0 : last ? 5'd0 : pos + 5'd1;
         next_ch   = bound ? (~pcm & ws_in) : (last ? ~ch : ch);
         next_ws_q = ws_in;
         next_ws_drv = pcm ? (next_pos == 5'd0) & ~next_ch : next_ch;
         if (next_pos == start) begin
            // left-align sample so the msb leaves first
            load        = 1'b1;
            tx_load_udf = ctrl[`AST_CTRL_TXEN] & tx_empty;
            next_txsh   = (ctrl[`AST_CTRL_TXEN] & ~tx_empty) ?
                          tx_head << (6'd32 - dl) : 32'h0;
            next_txrem  = 5'(dl - 6'd1);
            next_sd_drv = next_txsh[31];
            next_txsh   = {next_txsh[30:0], 1'b0};
         end else if (txrem != 5'd0) begin
            next_sd_drv = txsh[31];
            next_txsh   = {txsh[30:0], 1'b0};
            next_txrem  = txrem - 5'd1;
         end else begin
            next_sd_drv = 1'b0;
         end
      end
      // receive only when enabled; tx and rx run independently
      if (run && rise && ctrl[`AST_CTRL_RXEN]) begin
         if (pos == start) begin
            next_rxsh  = {31'h0, sd_in};
            next_rxrem = 5'(dl - 6'd1);
         end else if (rxrem != 5'd0) begin
            next_rxsh  = {rxsh[30:0], sd_in};
            next_rxrem = rxrem - 5'd1;
            rx_done    = (rxrem == 5'd1);
         end
      end
      if (!run) begin
         // park on the last bit so the first fall opens a left slot
         next_pos    = 5'(slot - 6'd1);
         next_ch     = 1'b1;
         next_ws_q   = ws_in;
         next_ws_drv = 1'b0;
         next_sd_drv = 1'b0;
         next_txrem  = 5'd0;
         next_rxrem  = 5'd0;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state  <= AST_OFF;
         pos    <= 5'd0;
         ch     <= 1'b1;
         ws_q   <= 1'b0;
         sck_q  <= 1'b0;
         ws_drv <= 1'b0;
         sd_drv <= 1'b0;
         txsh   <= 32'h0;
         txrem  <= 5'd0;
         rxsh   <= 32'h0;
         rxrem  <= 5'd0;
      end else begin
         state  <= next_state;
         pos    <= next_pos;
         ch     <= next_ch;
         ws_q   <= next_ws_q;
         sck_q  <= next_sck_q;
         ws_drv <= next_ws_drv;
         sd_drv <= next_sd_drv;
         txsh   <= next_txsh;
         txrem  <= next_txrem;
         rxsh   <= next_rxsh;
         rxrem  <= next_rxrem;
      end
   end

   property p_txovf;
      @(posedge clk) disable iff (!reset_n)
      (wr && adr == `AST_ADR_TXDATA && tx_full) |=> stat[`AST_ST_TXOVF];
   endproperty
   a_txovf: assert property (p_txovf)
      else $error("tx overflow not flagged");

   property p_rxovf;
      @(posedge clk) disable iff (!reset_n)
      (rx_done && rx_full && !rx_pop)
         |=> stat[`AST_ST_RXOVF] && $stable(rx_level);
   endproperty
   a_rxovf: assert property (p_rxovf)
      else $error("rx overflow not flagged");

   property p_udf;
      @(posedge clk) disable iff (!reset_n)
      (load && tx_empty && ctrl[`AST_CTRL_TXEN])
         |=> stat[`AST_ST_TXUDF] && !txsh[31];
   endproperty
   a_udf: assert property (p_udf)
      else $error("tx underflow not flagged");

   property p_slave;
      @(posedge clk) disable iff (!reset_n)
      !master |-> !sck_oe && !ws_oe;
   endproperty
   a_slave: assert property (p_slave)
      else $error("slave drives clock pins");

   property p_rjzero;
      @(posedge clk) disable iff (!reset_n)
      (run && fmt == AST_FMT_RJ && $rose(fall) && txrem == 5'd0
       && next_pos < start) |=> !sd_drv;
   endproperty
   a_rjzero: assert property (p_rjzero)
      else $error("leading right-justified bit not zero");

   property p_rxa;
      @(posedge clk) disable iff (!reset_n)
      (run && ctrl[`AST_CTRL_RXEN] && rx_level >= ctrl[`AST_CTRL_RXTHR])
         |=> stat[`AST_ST_RXA];
   endproperty
   a_rxa: assert property (p_rxa)
      else $error("rx alarm missing");

   property p_txa;
      @(posedge clk) disable iff (!reset_n)
      (run && ctrl[`AST_CTRL_TXEN] && tx_empty
       && ctrl[`AST_CTRL_TXTHR] <= 3'h4) |=> stat[`AST_ST_TXA];
   endproperty
   a_txa: assert property (p_txa)
      else $error("tx alarm missing");

   property p_ack;
      @(posedge clk) disable iff (!reset_n)
      (wb_cyc && wb_stb && !wb_ack) |=> wb_ack ##1 !wb_ack;
   endproperty
   a_ack: assert property (p_ack)
      else $error("bus answer not one cycle");
endmodule // ast_top
`default_nettype wire

// ==== ast_params.svh ====
// register map, field positions, reset values of the audio serial port
// assumes a 32-bit classic wishbone slave with byte addressing
`ifndef AST_PARAMS_SVH
`define AST_PARAMS_SVH

// register offsets (byte addresses)
`define AST_ADR_CTRL   8'h00
`define AST_ADR_PRESC  8'h04
`define AST_ADR_TXDATA 8'h08
`define AST_ADR_RXDATA 8'h0C
`define AST_ADR_STAT   8'h10
`define AST_ADR_MASK   8'h14
`define AST_ADR_LEVEL  8'h18

// control register fields
`define AST_CTRL_EN     0
`define AST_CTRL_MASTER 1
`define AST_CTRL_TXEN   2
`define AST_CTRL_RXEN   3
`define AST_CTRL_FMT    5:4
`define AST_CTRL_CH32   6
`define AST_CTRL_DLEN   8:7
`define AST_CTRL_MCKEN  9
`define AST_CTRL_EXTCLK 10
`define AST_CTRL_TXTHR  14:12
`define AST_CTRL_RXTHR  18:16

// status and mask bits
`define AST_ST_TXA   0
`define AST_ST_RXA   1
`define AST_ST_RXOVF 2
`define AST_ST_TXUDF 3
`define AST_ST_TXOVF 4
`define AST_NSTAT    5

// reset values
`define AST_RST_CTRL  32'h0001_2000
`define AST_RST_PRESC 8'h04
`define AST_RST_MASK  5'h00

// fifo geometry
`define AST_FIFO_DEPTH 4
`define AST_FIFO_AW    2
`define AST_WORD       32

`endif

// ==== ast_pkg.sv ====
// types shared by the audio serial port modules
// assumes nothing beyond a systemverilog compiler
`default_nettype none
package ast_pkg;
   // frame formats
   typedef enum logic [1:0] {
      AST_FMT_STD = 2'h0,
      AST_FMT_LJ  = 2'h1,
      AST_FMT_RJ  = 2'h2,
      AST_FMT_PCM = 2'h3
   } ast_fmt_t;
   // sample lengths, code 3 acts as 32
   typedef enum logic [1:0] {
      AST_DL16 = 2'h0,
      AST_DL24 = 2'h1,
      AST_DL32 = 2'h2,
      AST_DLX  = 2'h3
   } ast_dlen_t;
   // serial engine run state, one-hot
   typedef enum logic [1:0] {
      AST_OFF = 2'h1,
      AST_RUN = 2'h2
   } ast_state_t;
endpackage : ast_pkg
`default_nettype wire

// ==== ast_fifo.sv ====
// four-word by 32-bit fifo used for both transmit and receive
// assumes caller never pushes when full or pops when empty
`default_nettype none
`include "ast_params.svh"
module ast_fifo (
   input  wire logic        clk,       // bus clock
   input  wire logic        reset_n,   // sync reset, active low
   input  wire logic        push,      // write one word
   input  wire logic [31:0] push_data, // word written
   input  wire logic        pop,       // drop head word
   output logic      [31:0] head,      // head word
   output logic             full,      // no room
   output logic             empty,     // nothing stored
   output logic      [2:0]  level      // words stored
);
   logic [31:0]                 mem [`AST_FIFO_DEPTH];
   logic [`AST_FIFO_AW-1:0]     wp, rp, next_wp, next_rp;
   logic [2:0]                  next_level;

   // pointer and count updates
   always_comb begin
      next_wp    = push ? wp + 2'h1 : wp;
      next_rp    = pop ? rp + 2'h1 : rp;
      next_level = level + {2'h0, push} - {2'h0, pop};
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wp    <= 2'h0;
         rp    <= 2'h0;
         level <= 3'h0;
      end else begin
         wp    <= next_wp;
         rp    <= next_rp;
         level <= next_level;
      end
      if (push) begin
         mem[wp] <= push_data;
      end
   end

   assign head  = mem[rp];
   assign full  = (level == 3'h4);
   assign empty = (level == 3'h0);

   property p_depth;
      @(posedge clk) disable iff (!reset_n) level <= 3'h4;
   endproperty
   a_depth: assert property (p_depth) else $error("fifo beyond 4 words");
endmodule // ast_fifo
`default_nettype wire

// ==== ast_clkdiv.sv ====
// prescaler making master clock and bit clock from source clock edges
// assumes src_edge is a one-cycle pulse per source clock rising edge
`default_nettype none
module ast_clkdiv (
   input  wire logic       clk,       // bus clock
   input  wire logic       reset_n,   // sync reset, active low
   input  wire logic       run,       // engine running
   input  wire logic       src_edge,  // source clock edge
   input  wire logic [7:0] presc,     // edges per half mclk period
   input  wire logic       ch32,      // 32-bit slots
   output logic            mclk,      // 256 x sample rate
   output logic            bclk,      // bit clock level
   output logic            bclk_rise, // bit clock rises now
   output logic            bclk_fall  // bit clock falls now
);
   logic [7:0] cnt, next_cnt;
   logic [2:0] ph, next_ph;
   logic       next_mclk, next_bclk, tick, flip;

   // one mclk half period per presc edges; 0 behaves as 1
   always_comb begin
      tick      = run & src_edge & (cnt + 8'h1 >= presc);
      flip      = tick & (ch32 ? (ph[1:0] == 2'h3) : (ph == 3'h7));
      next_cnt  = !run ? 8'h0 : tick ? 8'h0 : src_edge ? cnt + 8'h1 : cnt;
      next_ph   = !run ? 3'h0 : tick ? ph + 3'h1 : ph;
      next_mclk = run & (tick ? ~mclk : mclk);
      next_bclk = run & (flip ? ~bclk : bclk);
      bclk_rise = flip & ~bclk;
      bclk_fall = flip & bclk;
   end

   // slot of 32 bits: 4 mclk per bclk, slot of 16: 8, so mclk=256 Fs
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cnt  <= 8'h0;
         ph   <= 3'h0;
         mclk <= 1'b0;
         bclk <= 1'b0;
      end else begin
         cnt  <= next_cnt;
         ph   <= next_ph;
         mclk <= next_mclk;
         bclk <= next_bclk;
      end
   end
endmodule // ast_clkdiv
`default_nettype wire

// ==== ast_codec.sv ====
// external codec model: takes bit clock and word select from the device
// assumes the device is master with 32-clock slots, one clock domain
`default_nettype none
module ast_codec #(
   parameter logic [31:0] PAT = 32'hC3A5_5A3C // word sent in every slot
) (
   input  wire logic        clk,     // bus clock
   input  wire logic        reset_n, // sync reset, active low
   input  wire logic        sck,     // bit clock from device
   input  wire logic        ws,      // word select from device
   input  wire logic        sd,      // serial data from device
   output logic             sd_in,   // serial data to device
   output logic      [31:0] wd,      // last slot word seen
   output logic             wd_stb   // new slot word, one cycle
);
   timeunit 1ns;
   timeprecision 1ns;
   logic        sck_q;
   logic        ws_q;
   logic [4:0]  i;
   logic [31:0] sh;
   // shift in at rise, out at fall, so a bit settles before its rise
   always @(posedge clk) begin
      if (!reset_n) begin
         sck_q  <= 1'b0;
         ws_q   <= 1'b0;
         i      <= 5'h1E; // bit clock rises once before its first fall
         sh     <= 32'h0000_0000;
         wd     <= 32'h0000_0000;
         sd_in  <= PAT[31];
         wd_stb <= 1'b0;
      end else begin
         sck_q  <= sck;
         wd_stb <= 1'b0;
         if (sck && !sck_q) begin
            sh   <= {sh[30:0], sd};
            ws_q <= ws;
            if (ws !== ws_q) begin
               i      <= 5'h00;
               wd     <= sh;
               wd_stb <= 1'b1;
            end else begin
               i <= i + 5'h01;
            end
         end
         // index wraps so the msb is ready before the slot's first rise
         if (!sck && sck_q) sd_in <= PAT[5'd30 - i];
      end
   end
endmodule // ast_codec
`default_nettype wire

// ==== tb_top.sv ====
// testbench of the audio serial transceiver with a codec model
// assumes ast_top, ast_codec and the register map header
`default_nettype none
`include "ast_params.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [31:0] PAT = 32'hC3A5_5A3C;
   logic clk = 0, reset_n = 0, cyc = 0, stb = 0, we = 0, kclk = 0, xclk = 0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] dw = 32'h0000_0000, dr, q, wd;
   logic ack, sck, sck_oe, ws, ws_oe, sdo, sdi, mck, irq, wd_stb;
   logic [31:0] seen [$];
   int n_fail = 0, checked = 0, k, nm, ns, nc;
   ast_top DUT (.clk(clk), .reset_n(reset_n), .wb_cyc(cyc), .wb_stb(stb),
      .wb_we(we), .wb_adr(adr), .wb_sel(4'hF), .wb_dat_w(dw),
      .wb_dat_r(dr), .wb_ack(ack), .audio_kernel_clock(kclk),
      .external_audio_clock_pin(xclk), .sck_in(1'b0), .sck_out(sck),
      .sck_oe(sck_oe), .ws_in(1'b0), .ws_out(ws), .ws_oe(ws_oe),
      .sd_in(sdi), .sd_out(sdo), .mclk_out(mck), .irq(irq));
   ast_codec #(.PAT(PAT)) codec (.clk(clk), .reset_n(reset_n), .sck(sck),
      .ws(ws), .sd(sdo), .sd_in(sdi), .wd(wd), .wd_stb(wd_stb));
   always #50 clk = ~clk;
   // kernel clock at half the bus rate
   always @(posedge clk) kclk <= ~kclk;
   // external source at a quarter of the bus rate, so its choice shows
   always @(posedge clk) if (kclk) xclk <= ~xclk;
   always @(posedge clk) if (wd_stb === 1'b1) seen.push_back(wd);
   task automatic check(input string nme, input logic [31:0] s, e);
      checked++;
      if (s !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nme, e, s);
      end
   endtask
   // one classic cycle; held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      int t;
      t = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dw  <= d;
      do @(posedge clk); while (ack !== 1'b1 && ++t < 50);
      q = dr;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (t >= 50) n_fail++;
   endtask
   // edges of master and bit clock from one word select rise to the next
   task automatic frame();
      logic pm, ps, pw;
      int r;
      r = 0;
      nm = 0;
      ns = 0;
      nc = 0;
      k = 0;
      pw = ws;
      while (r < 2 && k++ < 5000) begin
         @(posedge clk);
         if (ws && !pw) r++;
         if (r == 1) begin
            nm += int'(mck && !pm);
            ns += int'(sck && !ps);
            nc++;
         end
         pm = mck;
         ps = sck;
         pw = ws;
      end
   endtask
   task automatic tally_and_finish();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #5000000;
      n_fail++;
      tally_and_finish();
   end
   initial begin
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      check("irq", irq, 32'h0);
      wb(0, `AST_ADR_CTRL, 0);
      check("ctrl", q, 32'h0001_2000);
      wb(0, `AST_ADR_PRESC, 0);
      check("presc", q, 32'h0000_0004);
      wb(0, 8'h1C, 0);
      check("unmapped", q, 32'h0);
      $display("test reset done");
      wb(1, `AST_ADR_MASK, 32'h10);
      for (int n = 0; n < 5; n++) wb(1, `AST_ADR_TXDATA, 32'h8123_45F0 + n);
      wb(0, `AST_ADR_LEVEL, 0);
      check("level", q, 32'h4);
      check("irq", irq, 32'h1);
      wb(0, `AST_ADR_STAT, 0);
      check("stat", q, 32'h10);
      wb(1, `AST_ADR_STAT, 32'h1F);
      wb(0, `AST_ADR_STAT, 0);
      check("stat", q, 32'h0);
      check("irq", irq, 32'h0);
      $display("test fifo done");
      wb(1, `AST_ADR_PRESC, 1);
      wb(1, `AST_ADR_CTRL, 32'h0001_235F);
      frame();
      check("mclk", nm, 256);
      check("sck", ns, 64);
      check("frame", nc, 1024);
      check("oe", {sck_oe, ws_oe}, 32'h3);
      k = 0;
      while (seen.size() < 6 && k++ < 8000) @(posedge clk);
      for (int n = 0; n < 4; n++) check("tx", seen[n], 32'h8123_45F0 + n);
      check("udf", seen[4], 32'h0);
      wb(1, `AST_ADR_CTRL, 32'h0001_2000);
      wb(0, `AST_ADR_STAT, 0);
      check("stat", q, 32'hF);
      for (int n = 0; n < 4; n++) begin
         wb(0, `AST_ADR_RXDATA, 0);
         check("rx", q, PAT);
      end
      $display("test stream done");
      wb(1, `AST_ADR_TXDATA, 32'hFFFF_BEEF);
      wb(1, `AST_ADR_CTRL, 32'h0001_2467);
      k = 0;
      while (ws !== 1'b1 && k++ < 3000) @(posedge clk);
      seen.delete();
      k = 0;
      while (seen.size() < 1 && k++ < 3000) @(posedge clk);
      check("rj", seen[0], 32'h0000_BEEF);
      frame();
      check("extclk", nc, 2048);
      check("mclk off", nm, 0);
      $display("test right justified done");
      tally_and_finish();
   end
endmodule // tb_top
`default_nettype wire
